// >>> verilog/lta_pkg.sv
// Constants, types and carriers of the literal, table and add/and decoder
`default_nettype none
package lta_pkg;
	////////////////////////////////////////////////////////////////////////
	// Register offsets on the bus
	localparam logic [7:0] OFS_INSTR  = 8'h00;
	localparam logic [7:0] OFS_ACC    = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_BANK   = 8'h0c;
	localparam logic [7:0] OFS_TPTR   = 8'h10;
	localparam logic [7:0] OFS_TLAT   = 8'h14;
	localparam logic [7:0] OFS_PROD   = 8'h18;
	localparam logic [7:0] OFS_PTR0   = 8'h1c;
	localparam logic [7:0] OFS_PTR1   = 8'h20;
	localparam logic [7:0] OFS_PTR2   = 8'h24;
	// Status field positions: {neg, ovf, zero, dcarry, carry}
	localparam int FL_C    = 0;
	localparam int FL_HC   = 1;
	localparam int FL_Z    = 2;
	localparam int FL_VF   = 3;
	localparam int FL_N    = 4;
	localparam int ST_BUSY = 8;
	// Widths and reset values
	localparam int TP_W = 21;
	localparam int DA_W = 12;
	localparam logic [7:0] ACC_RST   = 8'h00;
	localparam logic [4:0] FLAGS_RST = 5'h00;
	// Special data addresses
	localparam logic [7:0]      ACC_SPLIT = 8'h80;
	localparam logic [3:0]      ACC_HIGH  = 4'hf;
	localparam logic [DA_W-1:0] PINS_ADR  = 12'hf81;
	localparam logic [DA_W-1:0] TZC_ADR   = 12'hfd6;
	// Upper opcode fields
	localparam logic [7:0] OPC_ADDL  = 8'h0f;
	localparam logic [7:0] OPC_ANDL  = 8'h0b;
	localparam logic [7:0] OPC_IORL  = 8'h09;
	localparam logic [7:0] OPC_XORL  = 8'h0a;
	localparam logic [7:0] OPC_SUBL  = 8'h08;
	localparam logic [7:0] OPC_MOVL  = 8'h0e;
	localparam logic [7:0] OPC_MULL  = 8'h0d;
	localparam logic [7:0] OPC_RETL  = 8'h0c;
	localparam logic [7:0] OPC_LPTR  = 8'hee;
	localparam logic [7:0] OPC_BANK  = 8'h01;
	localparam logic [11:0] OPC_TBL  = 12'h000;
	localparam logic [5:0] OPC_ADDF  = 6'b001001;
	localparam logic [5:0] OPC_ADDFC = 6'b001000;
	localparam logic [5:0] OPC_ANDF  = 6'b000101;
	localparam logic [3:0] OPC_SECW  = 4'hf;
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000, PH_Q1 = 3'b001, PH_Q2 = 3'b010,
		PH_Q3 = 3'b011, PH_Q4 = 3'b100, PH_HOLD = 3'b101
	} lta_phase_t;
	typedef enum logic [4:0] {
		OP_NOP = 5'b00000, OP_ADDL = 5'b00001, OP_ANDL = 5'b00010,
		OP_IORL = 5'b00011, OP_XORL = 5'b00100, OP_SUBL = 5'b00101,
		OP_MOVL = 5'b00110, OP_BANK = 5'b00111, OP_MULL = 5'b01000,
		OP_RETL = 5'b01001, OP_LPT1 = 5'b01010, OP_LPT2 = 5'b01011,
		OP_TABLE_READ_OP = 5'b01100, OP_TABLE_WRITE_OP = 5'b01101, OP_ADDF = 5'b01110,
		OP_ADDFC = 5'b01111, OP_ANDF = 5'b10000
	} lta_op_t;
	typedef struct packed {
		logic [DA_W-1:0] addr;
		logic [7:0]      wdata;
		logic            we;
	} lta_dmem_req_t;
	typedef struct packed {
		logic [TP_W-1:0] addr;
		logic [7:0]      wdata;
		logic            rd;
		logic            wr;
	} lta_prog_req_t;
endpackage
`default_nettype wire

// >>> verilog/lta_core.sv
// Decode and execute engine with its bus register file
`default_nettype none
module lta_core (
	// Clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// Register bus
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic                   hready,
	input  wire logic [31:0]            hwdata,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	// Data memory
	output lta_pkg::lta_dmem_req_t      dmem_req,
	input  wire logic [7:0]             dmem_rdata,
	input  wire logic [7:0]             port_b_pins,
	// Program memory
	output lta_pkg::lta_prog_req_t      prog_req,
	input  wire logic [7:0]             prog_rdata,
	input  wire logic                   prog_busy,
	// Core side effects
	input  wire logic                   tzero_pre_assigned,
	output logic                        tzero_pre_clr,
	output logic                        ret_pop
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		lta_pkg::lta_phase_t        ph;
		logic                       cyc2;
		lta_pkg::lta_op_t           op;
		logic [15:0]                iw;
		logic                       lpt_pend;
		logic [1:0]                 lpt_sel;
		logic [3:0]                 lpt_hi;
		logic [7:0]                 acc;
		logic [4:0]                 flags;
		logic [3:0]                 bank;
		logic [2:0][11:0]           ptr;
		logic [lta_pkg::TP_W-1:0]   tptr;
		logic [7:0]                 tlat;
		logic [15:0]                prod;
		logic [7:0]                 opnd;
		logic [7:0]                 res;
		logic [4:0]                 nflags;
		lta_pkg::lta_dmem_req_t     dreq;
		lta_pkg::lta_prog_req_t     preq;
		logic                       pre_clr;
		logic                       ret_pop;
		logic                       wr_pend;
		logic [7:0]                 wr_ofs;
		logic [31:0]                hrdata;
		logic                       hready;
	} lta_state_t;

	lta_state_t                 q;
	lta_state_t                 d;
	lta_pkg::lta_op_t           dec_op;
	logic [7:0]                 alu_res;
	logic [4:0]                 alu_fl;
	logic [31:0]                rd_val;
	logic [lta_pkg::DA_W-1:0]   f_addr;
	logic                       is_file;
	logic                       is_two;
	logic                       busy;

	assign busy = (q.ph != lta_pkg::PH_IDLE);
	assign is_file = (q.op == lta_pkg::OP_ADDF) ||
		(q.op == lta_pkg::OP_ADDFC) || (q.op == lta_pkg::OP_ANDF);
	assign is_two = (q.op == lta_pkg::OP_RETL) ||
		(q.op == lta_pkg::OP_TABLE_READ_OP) || (q.op == lta_pkg::OP_TABLE_WRITE_OP);

	////////////////////////////////////////////////////////////////////////
	// Instruction decode
	always_comb
	begin
		dec_op = lta_pkg::OP_NOP;
		case (q.iw[15:8])
			lta_pkg::OPC_ADDL: dec_op = lta_pkg::OP_ADDL;
			lta_pkg::OPC_ANDL: dec_op = lta_pkg::OP_ANDL;
			lta_pkg::OPC_IORL: dec_op = lta_pkg::OP_IORL;
			lta_pkg::OPC_XORL: dec_op = lta_pkg::OP_XORL;
			lta_pkg::OPC_SUBL: dec_op = lta_pkg::OP_SUBL;
			lta_pkg::OPC_MOVL: dec_op = lta_pkg::OP_MOVL;
			lta_pkg::OPC_MULL: dec_op = lta_pkg::OP_MULL;
			lta_pkg::OPC_RETL: dec_op = lta_pkg::OP_RETL;
			lta_pkg::OPC_LPTR: dec_op = lta_pkg::OP_LPT1;
			lta_pkg::OPC_BANK:
				if (q.iw[7:4] == 4'h0)
					dec_op = lta_pkg::OP_BANK;
			default: dec_op = lta_pkg::OP_NOP;
		endcase
		if (q.iw[15:4] == lta_pkg::OPC_TBL && q.iw[3:2] == 2'b10)
			dec_op = lta_pkg::OP_TABLE_READ_OP;
		if (q.iw[15:4] == lta_pkg::OPC_TBL && q.iw[3:2] == 2'b11)
			dec_op = lta_pkg::OP_TABLE_WRITE_OP;
		case (q.iw[15:10])
			lta_pkg::OPC_ADDF:  dec_op = lta_pkg::OP_ADDF;
			lta_pkg::OPC_ADDFC: dec_op = lta_pkg::OP_ADDFC;
			lta_pkg::OPC_ANDF:  dec_op = lta_pkg::OP_ANDF;
			default: ;
		endcase
		// second word consumed only after pointer load
		// lone top-nibble ones word is nop
		if (q.iw[15:12] == lta_pkg::OPC_SECW)
			dec_op = q.lpt_pend ? lta_pkg::OP_LPT2 : lta_pkg::OP_NOP;
	end

	assign f_addr = q.iw[8] ? {q.bank, q.iw[7:0]} :
		(q.iw[7:0] < lta_pkg::ACC_SPLIT) ? {4'h0, q.iw[7:0]} :
		{lta_pkg::ACC_HIGH, q.iw[7:0]};

	////////////////////////////////////////////////////////////////////////
	// Arithmetic and logic unit
	always_comb
	begin
		logic [7:0] a;
		logic [7:0] b;
		logic       ci;
		logic [8:0] s9;
		logic [4:0] h5;
		logic       arith;
		a = q.acc;
		b = q.opnd;
		ci = 1'b0;
		arith = 1'b1;
		s9 = 9'h000;
		h5 = 5'h00;
		alu_res = q.acc;
		case (q.op)
			lta_pkg::OP_ADDFC: ci = q.flags[lta_pkg::FL_C];
			// literal plus inverted register plus one
			lta_pkg::OP_SUBL:
			begin
				a = q.opnd;
				b = ~q.acc;
				ci = 1'b1;
			end
			default: arith = (q.op == lta_pkg::OP_ADDL) ||
				(q.op == lta_pkg::OP_ADDF);
		endcase
		s9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		h5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		alu_fl = q.flags;
		if (arith)
		begin
			alu_res = s9[7:0];
			alu_fl[lta_pkg::FL_C] = s9[8];
			alu_fl[lta_pkg::FL_HC] = h5[4];
			alu_fl[lta_pkg::FL_VF] = (a[7] == b[7]) && (s9[7] != a[7]);
		end
		case (q.op)
			lta_pkg::OP_ANDL: alu_res = q.acc & q.opnd;
			lta_pkg::OP_ANDF: alu_res = q.acc & q.opnd;
			lta_pkg::OP_IORL: alu_res = q.acc | q.opnd;
			lta_pkg::OP_XORL: alu_res = q.acc ^ q.opnd;
			default: ;
		endcase
		if (arith || q.op == lta_pkg::OP_ANDL || q.op == lta_pkg::OP_ANDF
			|| q.op == lta_pkg::OP_IORL || q.op == lta_pkg::OP_XORL)
		begin
			alu_fl[lta_pkg::FL_Z] = (alu_res == 8'h00);
			alu_fl[lta_pkg::FL_N] = alu_res[7];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register read mux
	always_comb
	begin
		case (haddr[7:0])
			lta_pkg::OFS_INSTR:  rd_val = {16'h0000, q.iw};
			lta_pkg::OFS_ACC:    rd_val = {24'h000000, q.acc};
			lta_pkg::OFS_STATUS: rd_val = {23'h0, busy, 3'h0, q.flags};
			lta_pkg::OFS_BANK:   rd_val = {28'h0, q.bank};
			lta_pkg::OFS_TPTR:   rd_val = {11'h0, q.tptr};
			lta_pkg::OFS_TLAT:   rd_val = {24'h000000, q.tlat};
			lta_pkg::OFS_PROD:   rd_val = {16'h0000, q.prod};
			lta_pkg::OFS_PTR0:   rd_val = {20'h0, q.ptr[0]};
			lta_pkg::OFS_PTR1:   rd_val = {20'h0, q.ptr[1]};
			lta_pkg::OFS_PTR2:   rd_val = {20'h0, q.ptr[2]};
			default:             rd_val = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		d = q;
		d.dreq.we = 1'b0;
		d.preq.rd = 1'b0;
		d.preq.wr = 1'b0;
		d.pre_clr = 1'b0;
		d.ret_pop = 1'b0;
		d.wr_pend = 1'b0;
		d.hready = 1'b1;
		if (hsel && htrans[1] && hready)
		begin
			d.wr_pend = hwrite;
			d.wr_ofs = haddr[7:0];
			d.hrdata = rd_val;
		end
		if (q.wr_pend && !busy)
		begin
			case (q.wr_ofs)
				lta_pkg::OFS_INSTR:
				begin
					d.iw = hwdata[15:0];
					d.ph = lta_pkg::PH_Q1;
					d.cyc2 = 1'b0;
				end
				lta_pkg::OFS_ACC:    d.acc = hwdata[7:0];
				lta_pkg::OFS_STATUS: d.flags = hwdata[4:0];
				lta_pkg::OFS_BANK:   d.bank = hwdata[3:0];
				lta_pkg::OFS_TPTR:   d.tptr = hwdata[lta_pkg::TP_W-1:0];
				lta_pkg::OFS_TLAT:   d.tlat = hwdata[7:0];
				default: ;
			endcase
		end
		case (q.ph)
			lta_pkg::PH_IDLE: ;
			lta_pkg::PH_Q1:
			begin
				d.ph = lta_pkg::PH_Q2;
				if (!q.cyc2)
				begin
					d.op = dec_op;
					d.lpt_pend = 1'b0;
					d.dreq.addr = f_addr;
				end
				d.preq.addr = q.tptr;
				d.preq.wdata = q.tlat;
				d.preq.rd = q.cyc2 && q.op == lta_pkg::OP_TABLE_READ_OP;
				d.preq.wr = q.cyc2 && q.op == lta_pkg::OP_TABLE_WRITE_OP;
			end
			lta_pkg::PH_Q2:
			begin
				d.ph = lta_pkg::PH_Q3;
				d.opnd = q.iw[7:0];
				if (is_file)
					d.opnd = (q.dreq.addr == lta_pkg::PINS_ADR) ?
						port_b_pins : dmem_rdata;
				if (q.cyc2 && q.op == lta_pkg::OP_TABLE_READ_OP)
					d.tlat = prog_rdata;
			end
			lta_pkg::PH_Q3:
			begin
				d.ph = lta_pkg::PH_Q4;
				d.res = alu_res;
				d.nflags = alu_fl;
				if (!q.cyc2 && is_file && q.iw[9])
				begin
					d.dreq.we = 1'b1;
					d.dreq.wdata = alu_res;
					d.pre_clr = tzero_pre_assigned &&
						(q.dreq.addr == lta_pkg::TZC_ADR);
				end
			end
			lta_pkg::PH_Q4:
			begin
				d.ph = lta_pkg::PH_IDLE;
				if (!q.cyc2)
				begin
					case (q.op)
						lta_pkg::OP_ADDL, lta_pkg::OP_SUBL,
						lta_pkg::OP_ANDL, lta_pkg::OP_IORL,
						lta_pkg::OP_XORL:
						begin
							d.acc = q.res;
							d.flags = q.nflags;
						end
						lta_pkg::OP_ADDF, lta_pkg::OP_ADDFC,
						lta_pkg::OP_ANDF:
						begin
							if (!q.iw[9])
								d.acc = q.res;
							d.flags = q.nflags;
						end
						lta_pkg::OP_MOVL: d.acc = q.opnd;
						lta_pkg::OP_BANK: d.bank = q.opnd[3:0];
						lta_pkg::OP_MULL: d.prod = 16'(q.acc) * 16'(q.opnd);
						lta_pkg::OP_RETL:
						begin
							d.acc = q.opnd;
							d.ret_pop = 1'b1;
						end
						// first word holds select and top nibble
						lta_pkg::OP_LPT1:
						begin
							d.lpt_pend = 1'b1;
							d.lpt_sel = q.iw[5:4];
							d.lpt_hi = q.iw[3:0];
						end
						lta_pkg::OP_LPT2:
							if (q.lpt_sel != 2'b11 && q.iw[11:8] == 4'h0)
								d.ptr[q.lpt_sel] = {q.lpt_hi, q.iw[7:0]};
						lta_pkg::OP_TABLE_READ_OP, lta_pkg::OP_TABLE_WRITE_OP:
							if (q.iw[1:0] == 2'b11)
								d.tptr = q.tptr + 1'b1;
						default: ;
					endcase
					if (is_two)
					begin
						d.ph = lta_pkg::PH_Q1;
						d.cyc2 = 1'b1;
					end
				end
				else
				begin
					if (q.iw[1:0] == 2'b01)
						d.tptr = q.tptr + 1'b1;
					if (q.iw[1:0] == 2'b10)
						d.tptr = q.tptr - 1'b1;
					if (q.op == lta_pkg::OP_TABLE_WRITE_OP && prog_busy)
						d.ph = lta_pkg::PH_HOLD;
				end
			end
			lta_pkg::PH_HOLD:
				if (!prog_busy)
					d.ph = lta_pkg::PH_IDLE;
			default: d.ph = lta_pkg::PH_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			q <= '0;
			q.acc <= lta_pkg::ACC_RST;
			q.flags <= lta_pkg::FLAGS_RST;
			q.hready <= 1'b1;
		end
		else
			q <= d;
	end

	assign hrdata = q.hrdata;
	assign hreadyout = q.hready;
	assign hresp = 1'b0;
	assign dmem_req = q.dreq;
	assign prog_req = q.preq;
	assign tzero_pre_clr = q.pre_clr;
	assign ret_pop = q.ret_pop;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	chk_add_sum: assert property (
		(q.ph == lta_pkg::PH_Q4 && q.op == lta_pkg::OP_ADDL && !q.cyc2)
		|=> q.acc == 8'($past(q.acc) + $past(q.opnd)))
		else $error("add literal result wrong");
	chk_logic_flags: assert property (
		(q.ph == lta_pkg::PH_Q4 && q.op == lta_pkg::OP_ANDL && !q.cyc2)
		|=> q.flags[lta_pkg::FL_C] == $past(q.flags[lta_pkg::FL_C])
		&& q.flags[lta_pkg::FL_Z] == (q.acc == 8'h00))
		else $error("and literal flags wrong");
	chk_move_flags: assert property (
		(q.ph == lta_pkg::PH_Q1 && dec_op == lta_pkg::OP_MOVL && !q.cyc2)
		|=> $stable(q.flags) [*4])
		else $error("load literal changed flags");
	chk_bank_load: assert property (
		(q.ph == lta_pkg::PH_Q4 && q.op == lta_pkg::OP_BANK && !q.cyc2)
		|=> q.bank == $past(q.iw[3:0]))
		else $error("bank select not loaded");
	chk_phase_walk: assert property (
		q.ph == lta_pkg::PH_Q1 |=> q.ph == lta_pkg::PH_Q2
		##1 q.ph == lta_pkg::PH_Q3 ##1 q.ph == lta_pkg::PH_Q4)
		else $error("phase order broken");
	chk_two_cycle: assert property (
		(q.ph == lta_pkg::PH_Q4 && !q.cyc2 && is_two)
		|=> q.ph == lta_pkg::PH_Q1 && q.cyc2)
		else $error("second cycle missing");
	chk_write_hold: assert property (
		(q.ph == lta_pkg::PH_HOLD && prog_busy)
		|=> q.ph == lta_pkg::PH_HOLD)
		else $error("write hold left early");
	chk_pin_operand: assert property (
		(q.ph == lta_pkg::PH_Q2 && is_file
		&& q.dreq.addr == lta_pkg::PINS_ADR)
		|=> q.opnd == $past(port_b_pins))
		else $error("port operand not from pins");
	chk_pre_clear: assert property (
		(q.ph == lta_pkg::PH_Q3 && is_file && q.iw[9] && !q.cyc2
		&& tzero_pre_assigned && q.dreq.addr == lta_pkg::TZC_ADR)
		|=> tzero_pre_clr && dmem_req.we)
		else $error("prescaler not cleared");

	cov_table_write_hold: cover property (q.ph == lta_pkg::PH_HOLD);
	cov_return_lit: cover property (ret_pop);
	cov_file_write: cover property (dmem_req.we);
endmodule
`default_nettype wire

// >>> bench/lta_mem_model.sv
// Behavioural data memory and program memory facing the decoder
`default_nettype none
module lta_mem_model (
	// Clock and reset
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// Data memory
	input  wire lta_pkg::lta_dmem_req_t dmem_req,
	output logic      [7:0]             dmem_rdata,
	// Program memory
	input  wire lta_pkg::lta_prog_req_t prog_req,
	output logic      [7:0]             prog_rdata,
	output logic                        prog_busy,
	// Length of a program write
	input  wire logic [3:0]             wr_len
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [4096];
	logic [20:0] wr_addr;
	logic [7:0]  wr_data;
	logic [3:0]  busy_cnt;
	logic [7:0]  junk;
	////////////////////////////////////////////////////////////////////////
	initial
		for (int i = 0; i < 4096; i++)
			mem[i] = i[7:0] ^ 8'h5a;
	assign dmem_rdata = mem[dmem_req.addr];
	// Read data stands only while rd is high
	assign prog_rdata = prog_req.rd ?
		(prog_req.addr[7:0] ^ prog_req.addr[15:8] ^ 8'hc3) : junk;
	assign prog_busy = busy_cnt != 4'h0;
	always @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			busy_cnt <= 4'h0;
			junk <= 8'h0;
		end
		else
		begin
			junk <= ~junk + 8'h1;
			if (dmem_req.we)
				mem[dmem_req.addr] <= dmem_req.wdata;
			if (prog_req.wr)
			begin
				wr_addr <= prog_req.addr;
				wr_data <= prog_req.wdata;
				busy_cnt <= wr_len;
			end
			else if (busy_cnt != 4'h0)
				busy_cnt <= busy_cnt - 4'h1;
		end
endmodule
`default_nettype wire

// >>> bench/lta_core_tb_top.sv
// Self-checking bench for the decoder core
`default_nettype none
module lta_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   hclk = 1'b0;
	logic                   hresetn = 1'b0;
	logic                   hsel = 1'b0;
	logic [31:0]            haddr = 32'h0;
	logic [1:0]             htrans = 2'h0;
	logic                   hwrite = 1'b0;
	logic [31:0]            hwdata = 32'h0;
	logic [31:0]            hrdata;
	logic                   hreadyout;
	logic                   hresp;
	lta_pkg::lta_dmem_req_t dmem_req;
	lta_pkg::lta_prog_req_t prog_req;
	logic [7:0]             dmem_rdata;
	logic [7:0]             prog_rdata;
	logic                   prog_busy;
	logic [7:0]             pins = 8'h0;
	logic                   pre_asg = 1'b0;
	logic                   pre_clr;
	logic                   ret_pop;
	logic [3:0]             wr_len = 4'h0;
	logic                   chk_on = 1'b0;
	logic                   dchk_q = 1'b0;
	logic [31:0]            exp_q[$];
	logic [31:0]            msk_q[$];
	string                  nm_q[$];
	logic [7:0]             mem_m[4096];
	logic [7:0]             w_m = 8'h0;
	logic [4:0]             fl_m = 5'h0;
	logic [3:0]             bank_m = 4'h0;
	logic [7:0]             lit_ops[9] = '{8'h0f, 8'h0b, 8'h09, 8'h0a,
		8'h08, 8'h0e, 8'h01, 8'h0d, 8'h0c};
	logic [5:0]             f_ops[3] = '{6'b001001, 6'b001000, 6'b000101};
	int                     failures = 0;
	int                     compares = 0;
	int                     cyc = 0;
	int                     clr_n = 0;
	int                     clr_e = 0;
	int                     pop_n = 0;
	int                     pop_e = 0;
	always #2 hclk = ~hclk;
	lta_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .dmem_req(dmem_req),
		.dmem_rdata(dmem_rdata), .port_b_pins(pins), .prog_req(prog_req),
		.prog_rdata(prog_rdata), .prog_busy(prog_busy),
		.tzero_pre_assigned(pre_asg), .tzero_pre_clr(pre_clr),
		.ret_pop(ret_pop));
	lta_mem_model mdl (.hclk(hclk), .hresetn(hresetn), .dmem_req(dmem_req),
		.dmem_rdata(dmem_rdata), .prog_req(prog_req),
		.prog_rdata(prog_rdata), .prog_busy(prog_busy), .wr_len(wr_len));
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic ahb_wr(input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	task automatic ahb_rd(input logic [7:0] a, input logic c,
		input string nm, input logic [31:0] e, m, output logic [31:0] d);
		if (c)
		begin
			exp_q.push_back(e & m);
			msk_q.push_back(m);
			nm_q.push_back(nm);
		end
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		chk_on <= c;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		chk_on <= 1'b0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
	task automatic issue(input logic [15:0] wd);
		logic [31:0] d;
		ahb_wr(lta_pkg::OFS_INSTR, {16'h0, wd});
		repeat (60)
		begin
			ahb_rd(lta_pkg::OFS_STATUS, 1'b0, "", 32'h0, 32'h0, d);
			if (d[lta_pkg::ST_BUSY] === 1'b0)
				break;
		end
	endtask
	task automatic state();
		logic [31:0] d;
		ahb_rd(lta_pkg::OFS_ACC, 1'b1, "accum", {24'h0, w_m}, 32'hff, d);
		ahb_rd(lta_pkg::OFS_STATUS, 1'b1, "status", {27'h0, fl_m},
			32'h11f, d);
	endtask
	// Sum with {carry, digit carry, overflow, result}
	function automatic logic [10:0] arith(input logic [7:0] a, b,
		input logic ci);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, b} + {8'h0, ci};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		return {s[8], h[4], (a[7] == b[7]) && (s[7] != a[7]), s[7:0]};
	endfunction
	task automatic fin(input logic [10:0] x, input logic ar, dd,
		input logic [11:0] ad);
		fl_m = {x[7], ar ? x[8] : fl_m[3], x[7:0] == 8'h0,
			ar ? x[9] : fl_m[1], ar ? x[10] : fl_m[0]};
		if (dd)
			mem_m[ad] = x[7:0];
		else
			w_m = x[7:0];
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge hclk)
	begin
		cyc++;
		if (pre_clr === 1'b1)
			clr_n++;
		if (ret_pop === 1'b1)
			pop_n++;
		if (dchk_q && hreadyout === 1'b1)
		begin
			check(nm_q[0], hrdata & msk_q[0], exp_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
			void'(nm_q.pop_front());
		end
		dchk_q <= hsel && htrans[1] && hreadyout && !hwrite && chk_on;
		if (cyc == 60000)
		begin
			failures++;
			close_out();
		end
	end
	initial
	begin
		logic [31:0] d;
		logic [7:0]  k, v, f, fv, pv, op;
		logic [11:0] ad, p0;
		logic [20:0] tp, ta;
		logic        dd, aa, pa;
		void'($urandom(90));
		for (int i = 0; i < 4096; i++)
			mem_m[i] = i[7:0] ^ 8'h5a;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check("hresp", {31'h0, hresp}, 32'h0);
		state();
		ahb_rd(8'h3c, 1'b1, "unmapped", 32'h0, 32'hffffffff, d);
		foreach (lit_ops[j])
			repeat (6)
			begin
				op = lit_ops[j];
				k = 8'($urandom);
				v = 8'($urandom);
				if (op == 8'h01)
					k = k & 8'h0f;
				issue({8'h0e, v});
				w_m = v;
				issue({op, k});
				case (op)
				8'h0f: fin(arith(v, k, 1'b0), 1'b1, 1'b0, 12'h0);
				8'h0b: fin({3'h0, v & k}, 1'b0, 1'b0, 12'h0);
				8'h09: fin({3'h0, v | k}, 1'b0, 1'b0, 12'h0);
				8'h0a: fin({3'h0, v ^ k}, 1'b0, 1'b0, 12'h0);
				8'h08: fin(arith(k, ~v, 1'b1), 1'b1, 1'b0, 12'h0);
				8'h0e: w_m = k;
				8'h01:
				begin
					bank_m = k[3:0];
					ahb_rd(lta_pkg::OFS_BANK, 1'b1, "bank", {24'h0, k},
						32'hf, d);
				end
				8'h0d: ahb_rd(lta_pkg::OFS_PROD, 1'b1, "prod",
					{16'h0, 16'(v) * 16'(k)}, 32'hffff, d);
				default:
				begin
					w_m = k;
					pop_e++;
				end
				endcase
				state();
			end
		for (int i = 0; i < 30; i++)
		begin
			op = 8'($urandom_range(2));
			{dd, aa, pa} = 3'($urandom);
			f = (i == 0) ? 8'h81 : (i == 1) ? 8'hd6 : 8'($urandom);
			aa = (i < 2) ? 1'b0 : aa;
			dd = (i == 1) ? 1'b1 : dd;
			pa = (i == 1) ? 1'b1 : pa;
			pv = 8'($urandom);
			pins <= pv;
			pre_asg <= pa;
			bank_m = 4'($urandom);
			issue({12'h010, bank_m});
			ad = aa ? {bank_m, f} : {f[7] ? 4'hf : 4'h0, f};
			fv = (ad == lta_pkg::PINS_ADR) ? pv : mem_m[ad];
			issue({f_ops[op], dd, aa, f});
			case (op)
			8'h0: fin(arith(w_m, fv, 1'b0), 1'b1, dd, ad);
			8'h1: fin(arith(w_m, fv, fl_m[0]), 1'b1, dd, ad);
			default: fin({3'h0, w_m & fv}, 1'b0, dd, ad);
			endcase
			if (dd && pa && ad == lta_pkg::TZC_ADR)
				clr_e++;
			check("mem", {24'h0, mdl.mem[ad]}, {24'h0, mem_m[ad]});
			state();
		end
		for (int m = 0; m < 8; m++)
		begin
			tp = 21'($urandom);
			k = 8'($urandom);
			wr_len <= 4'($urandom);
			ahb_wr(lta_pkg::OFS_TPTR, {11'h0, tp});
			ahb_wr(lta_pkg::OFS_TLAT, {24'h0, k});
			issue({12'h000, 4'h8 | 4'(m)});
			ta = (m[1:0] == 2'h3) ? tp + 21'h1 : tp;
			if (m < 4)
				ahb_rd(lta_pkg::OFS_TLAT, 1'b1, "tablat",
					{24'h0, ta[7:0] ^ ta[15:8] ^ 8'hc3}, 32'hff, d);
			else
			begin
				check("waddr", {11'h0, mdl.wr_addr}, {11'h0, ta});
				check("wdata", {24'h0, mdl.wr_data}, {24'h0, k});
				check("pbusy", {31'h0, prog_busy}, 32'h0);
			end
			tp = (m[1:0] == 2'h2) ? tp - 21'h1 :
				(m[1:0] == 2'h0) ? tp : tp + 21'h1;
			ahb_rd(lta_pkg::OFS_TPTR, 1'b1, "tblptr", {11'h0, tp},
				32'h1fffff, d);
			state();
		end
		for (int s = 0; s < 3; s++)
		begin
			k = 8'($urandom);
			v = 8'($urandom);
			issue({8'hee, 2'h0, 2'(s), k[3:0]});
			issue({8'hf0, v});
			if (s == 0)
				p0 = {k[3:0], v};
			ahb_rd(8'(lta_pkg::OFS_PTR0 + 8'(4 * s)), 1'b1, "ptr",
				{20'h0, k[3:0], v}, 32'hfff, d);
			state();
		end
		k = 8'($urandom);
		issue({8'hee, 4'h0, ~p0[11:8]});
		issue({8'h0e, k});
		w_m = k;
		issue({8'hf0, 8'($urandom)});
		issue({4'hf, 12'($urandom)});
		ahb_rd(lta_pkg::OFS_PTR0, 1'b1, "ptr0", {20'h0, p0}, 32'hfff,
			d);
		state();
		check("clr", clr_n, clr_e);
		check("pop", pop_n, pop_e);
		@(posedge hclk);
		check("drain", exp_q.size(), 0);
		close_out();
	end
endmodule
`default_nettype wire
